// >>> shared/adfr_pkg.sv
`default_nettype none
package adfr_pkg;
  // Core clock and link limits.
  localparam int CORE_CLK_PERIOD_NS = 40;
  localparam int SHIFT_OUT_MAX_MHZ  = 48;
  localparam int SHIFT_IN_MAX_MHZ   = 50;
  // Shortest legal half period of the driven shift clock, rounded up to core cycles.
  localparam int CLK_HALF_CYC_RAW   = (1000 + 2 * SHIFT_OUT_MAX_MHZ * CORE_CLK_PERIOD_NS - 1) /
                                      (2 * SHIFT_OUT_MAX_MHZ * CORE_CLK_PERIOD_NS);
  localparam int CLK_HALF_CYC       = (CLK_HALF_CYC_RAW < 1) ? 1 : CLK_HALF_CYC_RAW;
  // Frame geometry.
  localparam int NUM_CH     = 4;
  localparam int BYTE_BITS  = 8;
  localparam int WORD16     = 16;
  localparam int WORD24     = 24;
  localparam int HDR_BITS   = 8;
  localparam int SLOT_MAX   = 32;
  localparam int FRAME_MAX  = 128;
  localparam int PIN_CHAIN_DEVICES = 4;
  localparam int RES_ONE_PIN = 4;
  localparam int RES_TWO_PIN = 2;
  localparam int CNT_W      = 11;
  localparam int DEV_W      = 3;
  localparam int RATE_W     = 3;
  localparam int DIV_W      = 4;
  localparam int FIFO_DEPTH = 16;
  // Output format pin codes; the other codes select quad parallel output.
  localparam logic [1:0] FMT_SERIAL_ONE = 2'h0;
  localparam logic [1:0] FMT_SERIAL_TWO = 2'h1;
  // Header byte layout and data check code.
  localparam int HDR_ERR_BIT = 7;
  localparam int HDR_OK_BIT  = 6;
  localparam int CRC6_W      = 6;
  localparam logic [5:0] CRC6_POLY = 6'h27;
  localparam logic [5:0] CRC6_SEED = 6'h25;
  // Interface configuration byte: soft reset position.
  localparam int SOFT_RST_BIT = 1;
  // Register packet length in minimum-I/O mode.
  localparam int MINIO_PACKET_BITS = 24;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } adfr_state_t;
endpackage
`default_nettype wire

// >>> src/adfr_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module adfr_fifo
  import adfr_pkg::*;
#(
  parameter int W     = 96,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         I_CORE_CLK,
  input  wire logic         I_RSTN,
  // Fill side
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  // Drain side
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          ready_r, ready_nxt, push, pop;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    push     = i_in_valid & ready_r;
    pop      = i_out_ready & (cnt_r != '0);
    wp_nxt   = push ? ((wp_r == LAST_IDX) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt   = pop ? ((rp_r == LAST_IDX) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt  = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_nxt = (cnt_nxt != FULL_CNT);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      ready_r <= 1'b1;
    end else begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Storage carries no reset so it maps onto plain RAM.
  always_ff @(posedge I_CORE_CLK) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end

  assign o_in_ready  = ready_r;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem[rp_r];
endmodule // adfr_fifo
`default_nettype wire

// >>> src/adfr_framer.sv
`timescale 1ns/1ns
`default_nettype none
module adfr_framer
  import adfr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_RSTN,
  // Conversion results, four channels of 24 bits, channel 0 lowest
  input  wire logic [NUM_CH*WORD24-1:0] i_SAMPLE_DATA,
  input  wire logic                     i_SAMPLE_VALID,
  output logic                          o_SAMPLE_READY,
  input  wire logic                     i_CHIP_ERROR,
  input  wire logic                     i_FILTER_SETTLED,
  // Configuration
  input  wire logic [1:0]               i_OUTPUT_FORMAT_PINS,
  input  wire logic                     i_WORD_IS_24,
  input  wire logic                     i_HEADER_EN,
  input  wire logic                     i_DAISY_EN,
  input  wire logic                     i_REG_CONTROL,
  input  wire logic [DEV_W-1:0]         i_CHAIN_DEVICE_COUNT,
  input  wire logic [1:0]               i_AVG_RATIO,
  input  wire logic [2*NUM_CH-1:0]      i_PER_CHANNEL_RATE_SELECT,
  input  wire logic                     i_SHIFT_CLK_IS_OUT,
  input  wire logic                     i_REG_PORT_SLAVE,
  input  wire logic                     i_READBACK_PIN_SOURCE_SELECT,
  input  wire logic                     i_IF_CFG_WR,
  input  wire logic [7:0]               i_IF_CFG_WR_DATA,
  // Link
  input  wire logic                     i_RATE_FRAME_PIN,
  input  wire logic                     i_SAMPLE_SHIFT_CLOCK,
  output logic                          o_SAMPLE_SHIFT_CLOCK,
  output logic                          o_SAMPLE_SHIFT_CLOCK_OE,
  input  wire logic                     i_SERIAL_OUT_PIN_2,
  input  wire logic                     i_SERIAL_OUT_PIN_3,
  output logic                          o_SERIAL_OUT_PIN_0,
  output logic                          o_SERIAL_OUT_PIN_1,
  output logic                          o_SERIAL_OUT_PIN_2,
  output logic                          o_SERIAL_OUT_PIN_3,
  output logic                          o_SERIAL_OUT_PIN_0_OE,
  output logic                          o_SERIAL_OUT_PIN_1_OE,
  output logic                          o_SERIAL_OUT_PIN_2_OE,
  output logic                          o_SERIAL_OUT_PIN_3_OE,
  // Register readback pin sharing
  input  wire logic                     i_REG_READBACK_DATA,
  input  wire logic                     i_REG_READBACK_OE,
  output logic                          o_REGISTER_READBACK_PIN,
  output logic                          o_REGISTER_READBACK_PIN_OE,
  // Minimum-I/O and status
  input  wire logic                     i_CHIP_SELECT_SHARED_PIN,
  output logic                          o_MIN_IO_MODE,
  output logic                          o_REG_CHECK_FORCED,
  output logic [CNT_W-1:0]              o_FRAME_CLOCKS
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic int slot_bits(input logic w24, input logic hdr);
    return (w24 ? WORD24 : WORD16) + (hdr ? HDR_BITS : 0);
  endfunction

  function automatic logic [CNT_W-1:0] frame_clocks(input logic [1:0] fmt, input logic w24,
      input logic hdr, input logic regc, input logic [DEV_W-1:0] devs, input logic [1:0] avg);
    int rpp;
    int mult;
    rpp  = (fmt == FMT_SERIAL_ONE) ? RES_ONE_PIN : (fmt == FMT_SERIAL_TWO) ? RES_TWO_PIN : 1;
    // The count field holds devices minus one, so 0x01 clocks two devices.
    mult = regc ? int'(devs) + 1 : ((rpp == 1) ? 1 : PIN_CHAIN_DEVICES);
    return CNT_W'((slot_bits(w24, hdr) * rpp * mult) >> avg);
  endfunction

  function automatic logic [CRC6_W-1:0] crc6(input logic [WORD24-1:0] d, input logic w24);
    logic [CRC6_W-1:0] c;
    logic fb;
    c  = CRC6_SEED;
    fb = 1'b0;
    for (int i = WORD24 - 1; i >= 0; i--) begin
      if (w24 || i >= WORD24 - WORD16) begin
        fb = d[i] ^ c[CRC6_W-1];
        c  = {c[CRC6_W-2:0], 1'b0} ^ (fb ? CRC6_POLY : '0);
      end
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH*WORD24-1:0] fifo_data;
  logic                     fifo_valid, fifo_pop;

  adfr_fifo #(.W(NUM_CH * WORD24), .DEPTH(DEPTH)) u_fifo (
    .I_CORE_CLK  (I_CORE_CLK),
    .I_RSTN      (I_RSTN),
    .i_in_data   (i_SAMPLE_DATA),
    .i_in_valid  (i_SAMPLE_VALID),
    .o_in_ready  (o_SAMPLE_READY),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  adfr_state_t          state_r, state_nxt;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt, fclk_r, fclk_nxt;
  logic [DIV_W-1:0]     div_r, div_nxt;
  logic [RATE_W-1:0]    rate_cnt_r, rate_cnt_nxt;
  logic [FRAME_MAX-1:0] sr_r [NUM_CH];
  logic [FRAME_MAX-1:0] sr_nxt [NUM_CH];
  logic [WORD24-1:0]    held_r [NUM_CH];
  logic [WORD24-1:0]    held_nxt [NUM_CH];
  logic [NUM_CH-1:0]    pin_r, pin_nxt, oe_r, oe_nxt, due;
  logic                 clk_r, clk_nxt, clk_oe_r, clk_oe_nxt, rb_r, rb_nxt, rb_oe_r, rb_oe_nxt;
  logic                 rate_prev_r, sclk_prev_r, soft_r, soft_nxt;
  logic                 cs_prev_r, cs_seen_r, min_io_r, min_io_nxt;
  logic                 parallel, daisy_on, frame_start, shift_ev, slen_ok;
  localparam int POS_W = $clog2(FRAME_MAX);
  logic [SLOT_MAX-1:0]  slot;
  logic [HDR_BITS-1:0]  hdr;
  logic [POS_W-1:0]     chain_pos;

  assign parallel    = (i_OUTPUT_FORMAT_PINS != FMT_SERIAL_ONE) &&
                       (i_OUTPUT_FORMAT_PINS != FMT_SERIAL_TWO);
  // Pin control always assumes a chain unless quad parallel is chosen.
  assign daisy_on    = (i_REG_CONTROL ? i_DAISY_EN : 1'b1) & ~parallel;
  assign frame_start = i_RATE_FRAME_PIN & ~rate_prev_r;
  assign fifo_pop    = frame_start & ~soft_r;
  // A bit is launched at each rising edge of whichever shift clock is in use.
  assign shift_ev    = (state_r == ST_SHIFT) && (i_SHIFT_CLK_IS_OUT ?
                       (!clk_r && div_r == DIV_W'(CLK_HALF_CYC - 1)) :
                       (i_SAMPLE_SHIFT_CLOCK && !sclk_prev_r));
  assign slen_ok     = (fclk_r[2:0] == 3'h0);
  // Chain bits enter just below the own frame, so they follow it without a gap.
  assign chain_pos   = POS_W'(FRAME_MAX - slot_bits(i_WORD_IS_24, i_HEADER_EN) *
                       ((i_OUTPUT_FORMAT_PINS == FMT_SERIAL_ONE) ? RES_ONE_PIN : RES_TWO_PIN));

  always_comb begin
    int pin_i;
    int pos_i;
    pin_i = 0;
    pos_i = 0;
    slot  = '0;
    hdr   = '0;
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    div_nxt      = div_r;
    clk_nxt      = clk_r;
    rate_cnt_nxt = rate_cnt_r;
    fclk_nxt     = frame_clocks(i_OUTPUT_FORMAT_PINS, i_WORD_IS_24, i_HEADER_EN,
                                i_REG_CONTROL, i_CHAIN_DEVICE_COUNT, i_AVG_RATIO);
    pin_nxt      = pin_r;
    for (int c = 0; c < NUM_CH; c++) begin
      // A channel at rate 1/2^k refreshes when the low k period bits are zero.
      due[c]      = ((rate_cnt_r & ((RATE_W'(1) << i_PER_CHANNEL_RATE_SELECT[2*c +: 2]) - 1'b1))
                    == '0);
      held_nxt[c] = (frame_start && fifo_valid && due[c]) ?
                    fifo_data[c*WORD24 +: WORD24] : held_r[c];
      sr_nxt[c]   = sr_r[c];
    end
    if (frame_start) begin
      rate_cnt_nxt = rate_cnt_r + 1'b1;
      state_nxt    = ST_SHIFT;
      cnt_nxt      = fclk_nxt;
      div_nxt      = '0;
      clk_nxt      = 1'b0;
      for (int p = 0; p < NUM_CH; p++) begin
        sr_nxt[p] = '0;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        hdr = {i_CHIP_ERROR, i_FILTER_SETTLED, crc6(held_nxt[c], i_WORD_IS_24)};
        if (i_WORD_IS_24) begin
          slot = {held_nxt[c], i_HEADER_EN ? hdr : 8'h00};
        end else begin
          slot = {held_nxt[c][WORD24-1 -: WORD16], i_HEADER_EN ? hdr : 8'h00, 8'h00};
        end
        pin_i = (i_OUTPUT_FORMAT_PINS == FMT_SERIAL_ONE) ? 0 :
                (i_OUTPUT_FORMAT_PINS == FMT_SERIAL_TWO) ? c / 2 : c;
        pos_i = (i_OUTPUT_FORMAT_PINS == FMT_SERIAL_ONE) ? c :
                (i_OUTPUT_FORMAT_PINS == FMT_SERIAL_TWO) ? c % 2 : 0;
        // Slots abut back to back, so the frame is a whole number of bytes.
        sr_nxt[pin_i] = sr_nxt[pin_i] | ({slot, {(FRAME_MAX - SLOT_MAX){1'b0}}} >>
                        (pos_i * slot_bits(i_WORD_IS_24, i_HEADER_EN)));
      end
    end else if (state_r == ST_SHIFT) begin
      if (i_SHIFT_CLK_IS_OUT) begin
        div_nxt = (div_r == DIV_W'(CLK_HALF_CYC - 1)) ? '0 : div_r + 1'b1;
        if (div_r == DIV_W'(CLK_HALF_CYC - 1)) begin
          clk_nxt = ~clk_r;
          if (clk_r && cnt_r == '0) begin
            state_nxt = ST_DONE;
            clk_nxt   = 1'b0;
          end
        end
      end
      if (shift_ev) begin
        if (i_SHIFT_CLK_IS_OUT) begin
          cnt_nxt = cnt_r - 1'b1;
        end
        for (int p = 0; p < NUM_CH; p++) begin
          pin_nxt[p] = sr_r[p][FRAME_MAX-1];
          sr_nxt[p]  = {sr_r[p][FRAME_MAX-2:0], 1'b0};
        end
        // Downstream bits follow the own frame through the same shift stage.
        sr_nxt[0][chain_pos] = daisy_on & i_SERIAL_OUT_PIN_2;
        sr_nxt[1][chain_pos] = daisy_on & (i_OUTPUT_FORMAT_PINS == FMT_SERIAL_TWO) &
                               i_SERIAL_OUT_PIN_3;
      end
    end else if (state_r == ST_DONE) begin
      state_nxt = ST_IDLE;
    end
    if (soft_r) begin
      state_nxt    = ST_IDLE;
      rate_cnt_nxt = '0;
      cnt_nxt      = '0;
      clk_nxt      = 1'b0;
      pin_nxt      = '0;
      for (int p = 0; p < NUM_CH; p++) begin
        sr_nxt[p] = '0;
      end
    end
  end

  always_comb begin
    soft_nxt   = i_IF_CFG_WR & i_IF_CFG_WR_DATA[SOFT_RST_BIT] & i_REG_PORT_SLAVE;
    min_io_nxt = min_io_r & ~(cs_seen_r & (i_CHIP_SELECT_SHARED_PIN != cs_prev_r));
    clk_oe_nxt = i_SHIFT_CLK_IS_OUT;
    // Pin 0 and the readback pin never drive together.
    oe_nxt[0]  = ~i_READBACK_PIN_SOURCE_SELECT & ~i_REG_READBACK_OE;
    oe_nxt[1]  = (i_OUTPUT_FORMAT_PINS != FMT_SERIAL_ONE);
    oe_nxt[2]  = parallel;
    oe_nxt[3]  = parallel;
    rb_oe_nxt  = i_READBACK_PIN_SOURCE_SELECT | i_REG_READBACK_OE;
    rb_nxt     = i_READBACK_PIN_SOURCE_SELECT ? pin_nxt[0] : i_REG_READBACK_DATA;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_r     <= ST_IDLE;
      cnt_r       <= '0;
      fclk_r      <= '0;
      div_r       <= '0;
      clk_r       <= 1'b0;
      rate_cnt_r  <= '0;
      pin_r       <= '0;
      oe_r        <= '0;
      clk_oe_r    <= 1'b0;
      rb_r        <= 1'b0;
      rb_oe_r     <= 1'b0;
      rate_prev_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      soft_r      <= 1'b0;
      cs_prev_r   <= 1'b0;
      cs_seen_r   <= 1'b0;
      min_io_r    <= 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        sr_r[c]   <= '0;
        held_r[c] <= '0;
      end
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      fclk_r      <= fclk_nxt;
      div_r       <= div_nxt;
      clk_r       <= clk_nxt;
      rate_cnt_r  <= rate_cnt_nxt;
      pin_r       <= pin_nxt;
      oe_r        <= oe_nxt;
      clk_oe_r    <= clk_oe_nxt;
      rb_r        <= rb_nxt;
      rb_oe_r     <= rb_oe_nxt;
      rate_prev_r <= i_RATE_FRAME_PIN;
      sclk_prev_r <= i_SAMPLE_SHIFT_CLOCK;
      soft_r      <= soft_nxt;
      cs_prev_r   <= i_CHIP_SELECT_SHARED_PIN;
      cs_seen_r   <= 1'b1;
      min_io_r    <= min_io_nxt;
      for (int c = 0; c < NUM_CH; c++) begin
        sr_r[c]   <= sr_nxt[c];
        held_r[c] <= held_nxt[c];
      end
    end
  end

  assign o_SAMPLE_SHIFT_CLOCK       = clk_r;
  assign o_SAMPLE_SHIFT_CLOCK_OE    = clk_oe_r;
  assign o_SERIAL_OUT_PIN_0         = pin_r[0];
  assign o_SERIAL_OUT_PIN_1         = pin_r[1];
  assign o_SERIAL_OUT_PIN_2         = pin_r[2];
  assign o_SERIAL_OUT_PIN_3         = pin_r[3];
  assign o_SERIAL_OUT_PIN_0_OE      = oe_r[0];
  assign o_SERIAL_OUT_PIN_1_OE      = oe_r[1];
  assign o_SERIAL_OUT_PIN_2_OE      = oe_r[2];
  assign o_SERIAL_OUT_PIN_3_OE      = oe_r[3];
  assign o_REGISTER_READBACK_PIN    = rb_r;
  assign o_REGISTER_READBACK_PIN_OE = rb_oe_r;
  assign o_MIN_IO_MODE              = min_io_r;
  assign o_REG_CHECK_FORCED         = min_io_r;
  assign o_FRAME_CLOCKS             = fclk_r;

  ////////////////////////////////////////////////////////////////////////////
  chk_chain_inputs_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    $past(daisy_on) |-> !o_SERIAL_OUT_PIN_2_OE && !o_SERIAL_OUT_PIN_3_OE)
    else $error("chain input pin driven while chaining");
  chk_chain_shift_in: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (shift_ev && daisy_on && !soft_r && !frame_start)
      |=> sr_r[0][$past(chain_pos)] == $past(i_SERIAL_OUT_PIN_2))
    else $error("chain input bit not taken into shift stage");
  chk_pin0_launch: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (shift_ev && !soft_r && !frame_start) |=> o_SERIAL_OUT_PIN_0 == $past(sr_r[0][FRAME_MAX-1]))
    else $error("pin 0 bit not launched at shift edge");
  chk_clock_count: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (frame_start && !soft_r) |=> cnt_r == frame_clocks($past(i_OUTPUT_FORMAT_PINS),
      $past(i_WORD_IS_24), $past(i_HEADER_EN), $past(i_REG_CONTROL),
      $past(i_CHAIN_DEVICE_COUNT), $past(i_AVG_RATIO)))
    else $error("gated clock count differs from frame length");
  chk_byte_frames: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (i_AVG_RATIO == 2'h0) |=> slen_ok)
    else $error("frame length not a byte multiple");
  chk_rate_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (frame_start && !due[0]) |=> held_r[0] == $past(held_r[0]))
    else $error("divided channel refreshed off its period");
  chk_soft_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (i_IF_CFG_WR && i_IF_CFG_WR_DATA[SOFT_RST_BIT] && i_REG_PORT_SLAVE)
      |=> ##1 (state_r == ST_IDLE && rate_cnt_r == '0 && !soft_r))
    else $error("soft reset did not realign data port");
  chk_min_io_exit: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (cs_seen_r && i_CHIP_SELECT_SHARED_PIN != cs_prev_r) |=> !o_MIN_IO_MODE && o_REG_CHECK_FORCED == 1'b0)
    else $error("minimum-I/O mode kept after select toggle");
  chk_readback_copy: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    $past(i_READBACK_PIN_SOURCE_SELECT) |-> o_REGISTER_READBACK_PIN == o_SERIAL_OUT_PIN_0
      && !(o_SERIAL_OUT_PIN_0_OE && o_REGISTER_READBACK_PIN_OE))
    else $error("readback pin does not mirror pin 0 alone");
  chk_header_flags: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (frame_start && !soft_r && i_HEADER_EN && i_WORD_IS_24 && parallel)
      |=> sr_r[0][FRAME_MAX-WORD24-1 -: 2] == {$past(i_CHIP_ERROR), $past(i_FILTER_SETTLED)})
    else $error("header status bits misplaced");
endmodule // adfr_framer
`default_nettype wire

// >>> verif/adfr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adfr_host_model (
  // Core clock and captured link
  input  wire logic    I_CORE_CLK,
  input  wire logic    i_clear,
  input  wire logic    i_sclk,
  input  wire logic    i_pin0,
  input  wire logic    i_chain_bit,
  output logic         o_pin2,
  output logic [8:0]   o_count,
  output logic [255:0] o_bits
);
  logic prev_r;
  // A downstream device sending all ones still forms whole valid bytes.
  assign o_pin2 = i_chain_bit;
  always_ff @(posedge I_CORE_CLK) begin
    prev_r <= i_sclk;
    if (i_clear) begin
      o_count <= '0;
      o_bits <= '0;
    // Edges are seen at core rate, well inside both shift clock limits.
    end else if (i_sclk && !prev_r) begin
      o_bits <= {o_bits[254:0], i_pin0};
      o_count <= o_count + 9'h001;
    end
  end
endmodule // adfr_host_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adfr_pkg::*;
  logic I_CORE_CLK = 0, I_RSTN = 0, sv = 0, w24 = 0, hen = 0, den = 0, regc = 0, sco = 0;
  logic slv = 0, rbs = 0, cwr = 0, rate = 0, cs = 0, clr = 0, cbit = 0, cerr = 0, p2in;
  logic [1:0] fmt = 0, avg = 0;
  logic [2:0] devc = 0;
  logic [7:0] cwd = 0, rsel = 0;
  logic srdy, sclk, sclk_oe, p0, p1, p2, p3, p0oe, p1oe, p2oe, p3oe, rbp, rboe, mio, rcf;
  logic [10:0] fclk;
  logic [8:0] cnt;
  logic [255:0] bits;
  int err_count = 0, n_checks = 0, n;
  localparam logic [95:0] SMP = 96'hE187_440F_5A33_3C96_22A5_C311;
  logic [95:0] smp = SMP;
  localparam logic [10:0] TAB [5] = '{11'h000, 11'h3E8, 11'h420, 11'h1E6, 11'h700};
  always #20 I_CORE_CLK = ~I_CORE_CLK;
  adfr_framer u_adfr_framer (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .i_SAMPLE_DATA(smp),
    .i_SAMPLE_VALID(sv), .o_SAMPLE_READY(srdy), .i_CHIP_ERROR(cerr), .i_FILTER_SETTLED(1'b1),
    .i_OUTPUT_FORMAT_PINS(fmt), .i_WORD_IS_24(w24), .i_HEADER_EN(hen), .i_DAISY_EN(den),
    .i_REG_CONTROL(regc), .i_CHAIN_DEVICE_COUNT(devc), .i_AVG_RATIO(avg),
    .i_PER_CHANNEL_RATE_SELECT(rsel), .i_SHIFT_CLK_IS_OUT(sco), .i_REG_PORT_SLAVE(slv),
    .i_READBACK_PIN_SOURCE_SELECT(rbs), .i_IF_CFG_WR(cwr), .i_IF_CFG_WR_DATA(cwd),
    .i_RATE_FRAME_PIN(rate), .i_SAMPLE_SHIFT_CLOCK(1'b0), .o_SAMPLE_SHIFT_CLOCK(sclk),
    .o_SAMPLE_SHIFT_CLOCK_OE(sclk_oe), .i_SERIAL_OUT_PIN_2(p2in), .i_SERIAL_OUT_PIN_3(1'b0),
    .o_SERIAL_OUT_PIN_0(p0), .o_SERIAL_OUT_PIN_1(p1), .o_SERIAL_OUT_PIN_2(p2),
    .o_SERIAL_OUT_PIN_3(p3), .o_SERIAL_OUT_PIN_0_OE(p0oe), .o_SERIAL_OUT_PIN_1_OE(p1oe),
    .o_SERIAL_OUT_PIN_2_OE(p2oe), .o_SERIAL_OUT_PIN_3_OE(p3oe), .i_REG_READBACK_DATA(1'b1),
    .i_REG_READBACK_OE(1'b0), .o_REGISTER_READBACK_PIN(rbp), .o_REGISTER_READBACK_PIN_OE(rboe),
    .i_CHIP_SELECT_SHARED_PIN(cs), .o_MIN_IO_MODE(mio), .o_REG_CHECK_FORCED(rcf),
    .o_FRAME_CLOCKS(fclk));
  adfr_host_model u_adfr_host_model (.I_CORE_CLK(I_CORE_CLK), .i_clear(clr), .i_sclk(sclk),
    .i_pin0(p0), .i_chain_bit(cbit), .o_pin2(p2in), .o_count(cnt), .o_bits(bits));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge I_CORE_CLK);
  endtask
  // Reference check code of one 24-bit result, MSB first, restarted from the seed.
  function automatic logic [5:0] crc_ref(input logic [23:0] d);
    logic [5:0] c;
    c = CRC6_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[4:0], 1'b0} ^ ((d[i] ^ c[5]) ? CRC6_POLY : 6'h00);
    end
    return c;
  endfunction
  // Fields: format, word 24, header, chaining, register control, count field, averaging.
  task automatic set(input logic [10:0] c);
    {fmt, w24, hen, den, regc, devc, avg} <= c;
    cyc(2);
  endtask
  task automatic push();
    sv <= 1;
    cyc(1);
    sv <= 0;
  endtask
  // The host starts a frame with one rate pulse and waits long enough for all clocks.
  task automatic frame(input int k);
    clr <= 1;
    cyc(1);
    clr <= 0;
    rate <= 1;
    cyc(1);
    rate <= 0;
    cyc(2 * k + 8);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_counts();
    int e;
    for (int i = 0; i < 5; i++) begin
      set(TAB[i]);
      e = ((w24 ? 24 : 16) + (hen ? 8 : 0)) * (fmt == 0 ? 4 : fmt == 1 ? 2 : 1);
      e = (e * (fmt[1] ? 1 : !regc ? 4 : den ? devc + 1 : 1)) >> avg;
      chk("frame clocks", fclk, e);
    end
  endtask
  task automatic t_master();
    sco <= 1;
    set(11'h420);
    push();
    frame(16);
    chk("gated clocks", cnt, 16);
    chk("ch0 bits", bits[15:0], 16'hA5C3);
    chk("byte multiple", cnt % 8, 0);
  endtask
  task automatic t_header();
    cerr <= 1;
    set(11'h780);
    push();
    frame(32);
    chk("header clocks", cnt, 32);
    chk("header slot", bits[31:0], {SMP[23:0], 2'b11, crc_ref(SMP[23:0])});
  endtask
  task automatic t_fifo();
    n = 0;
    sv <= 1;
    repeat (20) begin
      @(negedge I_CORE_CLK);
      n += (srdy === 1'b1);
      @(posedge I_CORE_CLK);
    end
    sv <= 0;
    chk("fifo words", n, FIFO_DEPTH);
    chk("ready when full", srdy, 0);
    repeat (16) frame(16);
    chk("ready when drained", srdy, 1);
  endtask
  task automatic t_chain();
    cbit <= 1;
    set(11'h064);
    push();
    frame(128);
    chk("chain clocks", cnt, 128);
    chk("own frame", bits[127:64], 64'hA5C3_3C96_0F5A_E187);
    chk("forwarded", bits[63:0], {64{1'b1}});
  endtask
  task automatic t_soft();
    slv <= 1;
    cwd <= 8'h02;
    frame(-6);
    cwr <= 1;
    cyc(1);
    cwr <= 0;
    cyc(4);
    chk("clock idle", sclk, 0);
    n = cnt;
    cyc(20);
    chk("frame aborted", cnt, n);
  endtask
  // Channel 0 at a quarter rate keeps its first result through the next frame.
  task automatic t_rate();
    rsel <= 8'h02;
    smp <= {SMP[95:24], 24'h12_3456};
    set(11'h420);
    push();
    frame(16);
    chk("rate first", bits[15:0], 16'h1234);
    smp <= SMP;
    push();
    frame(16);
    chk("rate held", bits[15:0], 16'h1234);
  endtask
  task automatic t_pins();
    sco <= 0;
    fmt <= FMT_SERIAL_ONE;
    rbs <= 1;
    cyc(2);
    chk("readback copy", {rbp, p0oe, rboe}, {p0, 2'b01});
    rbs <= 0;
    cs <= 1;
    cyc(3);
    chk("min io exit", {mio, rcf}, 0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    I_RSTN <= 1;
    cyc(2);
    chk("reset state", {mio, rcf, srdy}, 3'b111);
    t_counts();
    t_master();
    t_header();
    t_fifo();
    t_chain();
    t_soft();
    t_rate();
    t_pins();
    tally_and_finish();
  end
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
